// ---- src/bc_cc_pkg.sv ----
/*
  Shared constants and types for the bus controller condition-code evaluator.
  Assumes a single 250 MHz clock domain shared by every user of the package.
*/
package bc_cc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] BC_CONFIG_OFFSET = 16'h0032;
  localparam logic [15:0] BC_CONFIG_RESET  = 16'h0000;
  localparam logic [7:0]  GP_FLAGS_RESET   = 8'h00;
  localparam int          CFG_TIMEOUT_HI   = 15;
  localparam int          CFG_TIMEOUT_LO   = 14;
  localparam int          CFG_BCAST_MASK_EN = 0;

  // ----------------------------------------------------------------
  // Message control word and RT status word fields
  // ----------------------------------------------------------------
  localparam int CW_MASK_HI      = 14;
  localparam int CW_MASK_LO      = 10;
  localparam int CW_RSVD_MASK    = 9;
  localparam int CW_MASK_BCAST   = 5;
  localparam int SW_ADDR_HI      = 15;
  localparam int SW_ADDR_LO      = 11;
  localparam int SW_RSVD_HI      = 7;
  localparam int SW_RSVD_LO      = 5;
  localparam int SW_BCAST_RCVD   = 4;
  // Status bit watched by control word mask bits 14..10, in that order
  localparam int SW_BIT_FOR_MASK [5] = '{10, 8, 3, 2, 0};

  // ----------------------------------------------------------------
  // Condition field
  // ----------------------------------------------------------------
  localparam int          CC_INVERT_BIT = 4;
  localparam logic [3:0]  CC_NO_REPLY   = 4'h8;
  localparam logic [3:0]  CC_FORMAT     = 4'h9;
  localparam logic [3:0]  CC_CLEAN_BLK  = 4'hA;
  localparam logic [3:0]  CC_MASKED     = 4'hB;
  localparam logic [3:0]  CC_FAULTY_MSG = 4'hC;
  localparam logic [3:0]  CC_RETRY_ANY  = 4'hD;
  localparam logic [3:0]  CC_RETRY_TWO  = 4'hE;
  localparam logic [3:0]  CC_ALWAYS     = 4'hF;
  localparam logic [1:0]  RETRY_NONE    = 2'h0;
  localparam logic [1:0]  RETRY_TWO     = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GP_HOLD,
    GP_SET,
    GP_CLEAR,
    GP_TOGGLE
  } gp_op_t;

  typedef enum logic [2:0] {
    MSG_RT_TO_BC,
    MSG_RT_TO_RT,
    MSG_TX_MODE_DATA,
    MSG_BC_TO_RT,
    MSG_RX_MODE_DATA,
    MSG_MODE_NO_DATA
  } msg_kind_t;

endpackage : bc_cc_pkg

// ---- src/cc_select.sv ----
/*
  Combinational condition-code selector: picks a flag with bits 3-0 of the
  condition field and applies the inverse sense on bit 4, except for code E, whose inverse reads as false.
  Assumes all flag inputs are registered by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module cc_select
  import bc_cc_pkg::*;
(
  // Condition field
  input  wire logic [4:0] cond,
  // Flags
  input  wire logic [7:0] gp_flags,
  input  wire logic       no_reply_flag,
  input  wire logic       format_fault_flag,
  input  wire logic       clean_block_flag,
  input  wire logic       masked_status_flag,
  input  wire logic       faulty_message_flag,
  input  wire logic [1:0] retries,
  // Result
  output logic            result
);

  logic       inv;
  logic [3:0] code;

  always_comb
  begin
    inv  = cond[CC_INVERT_BIT];
    code = cond[3:0];
    result = 1'b0;
    case (code)
      CC_NO_REPLY:   result = no_reply_flag ^ inv;
      CC_FORMAT:     result = format_fault_flag ^ inv;
      CC_CLEAN_BLK:  result = clean_block_flag ^ inv;
      CC_MASKED:     result = masked_status_flag ^ inv;
      CC_FAULTY_MSG: result = faulty_message_flag ^ inv;
      CC_RETRY_ANY:  result = inv ? (retries == RETRY_NONE)
                                  : (retries != RETRY_NONE);
      // Inverse of two-retries is undefined; it reads as false
      CC_RETRY_TWO:  result = inv ? 1'b0 : (retries == RETRY_TWO);
      CC_ALWAYS:     result = ~inv;
      default:       result = gp_flags[code[2:0]] ^ inv;
    endcase
  end

endmodule : cc_select
`default_nettype wire

// ---- src/bc_condition_code_eval.sv ----
/*
  Bus controller condition-code evaluation: keeps the general purpose flags,
  the configuration register and the last-message status flags, and decides
  whether a conditional op code executes or is skipped.
  Assumes the sequencer and message engine share this clock and give
  one-cycle pulses; the host reaches registers through a simple write port.
*/
`timescale 1ns/1ps
`default_nettype none
module bc_condition_code_eval
  import bc_cc_pkg::*;
#(
  parameter int GP_WIDTH = 8
)
(
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rstn,
  // Host register writes
  input  wire logic                cfg_write,
  input  wire logic [15:0]         cfg_wdata,
  input  wire logic                gp_host_write,
  input  wire gp_op_t              gp_host_op,
  input  wire logic [GP_WIDTH-1:0] gp_host_bits,
  // Sequencer flag op code
  input  wire logic                flg_exec,
  input  wire gp_op_t              flg_op,
  input  wire logic [GP_WIDTH-1:0] flg_bits,
  // Message completion report
  input  wire logic                msg_done,
  input  wire msg_kind_t           msg_kind,
  input  wire logic                msg_no_reply,
  input  wire logic                msg_bad_word,
  input  wire logic                msg_loopback_fault,
  input  wire logic [4:0]          msg_rt_addr,
  input  wire logic [15:0]         msg_status_word,
  input  wire logic [15:0]         msg_control_word,
  input  wire logic [1:0]          msg_retries,
  // Condition evaluation
  input  wire logic                eval_req,
  input  wire logic [4:0]          eval_cond,
  output logic                     eval_valid,
  output logic                     eval_true,
  output logic                     execute,
  output logic                     skip,
  // Register and flag views
  output logic [15:0]              bus_controller_configuration,
  output logic [1:0]               no_reply_timeout_sel,
  output logic [GP_WIDTH-1:0]      gp_flags,
  output logic                     no_reply_flag,
  output logic                     format_fault_flag,
  output logic                     clean_block_flag,
  output logic                     masked_status_flag,
  output logic                     faulty_message_flag
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]         cfg;
    logic [GP_WIDTH-1:0] gp;
    logic                no_reply;
    logic                format_fault;
    logic                clean_block;
    logic                masked;
    logic                faulty;
    logic [1:0]          retries;
    logic                valid;
    logic                result;
    logic                execute;
    logic                skip;
  } state_t;

  state_t state;
  state_t next_state;

  logic [GP_WIDTH-1:0] gp_after_flg;
  logic [GP_WIDTH-1:0] gp_after_host;
  logic [4:0]          mask_hits;
  logic                addr_fault;
  logic                fmt_now;
  logic                bad_now;
  logic                sel_result;

  // ----------------------------------------------------------------
  // General purpose flags, one cell per bit
  // ----------------------------------------------------------------
  // Op code applies first, host write second, so a host write in the
  // same cycle has the final say on the bits it touches.
  genvar gi;
  generate
    for (gi = 0; gi < GP_WIDTH; gi++)
    begin : g_gp
      always_comb
      begin
        gp_after_flg[gi] = state.gp[gi];
        if (flg_exec && flg_bits[gi])
        begin
          case (flg_op)
            GP_SET:    gp_after_flg[gi] = 1'b1;
            GP_CLEAR:  gp_after_flg[gi] = 1'b0;
            GP_TOGGLE: gp_after_flg[gi] = ~state.gp[gi];
            default:   gp_after_flg[gi] = state.gp[gi];
          endcase
        end
        gp_after_host[gi] = gp_after_flg[gi];
        if (gp_host_write && gp_host_bits[gi])
        begin
          case (gp_host_op)
            GP_SET:    gp_after_host[gi] = 1'b1;
            GP_CLEAR:  gp_after_host[gi] = 1'b0;
            GP_TOGGLE: gp_after_host[gi] = ~gp_after_flg[gi];
            default:   gp_after_host[gi] = gp_after_flg[gi];
          endcase
        end
      end
    end
    for (gi = 0; gi < 5; gi++)
    begin : g_mask
      assign mask_hits[gi] = ~msg_control_word[CW_MASK_HI - gi]
                           & msg_status_word[SW_BIT_FOR_MASK[gi]];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Message status decode
  // ----------------------------------------------------------------
  // No status word arrives without a reply, so address and mask checks
  // are only meaningful when one was received.
  assign addr_fault = ~msg_no_reply
                    & (msg_status_word[SW_ADDR_HI:SW_ADDR_LO] != msg_rt_addr);
  assign fmt_now    = msg_bad_word | addr_fault;
  // Masked status is deliberately absent here
  assign bad_now    = fmt_now | msg_no_reply | msg_loopback_fault;

  cc_select u_sel (
    .cond                (eval_cond),
    .gp_flags            (state.gp[7:0]),
    .no_reply_flag       (state.no_reply),
    .format_fault_flag   (state.format_fault),
    .clean_block_flag    (state.clean_block),
    .masked_status_flag  (state.masked),
    .faulty_message_flag (state.faulty),
    .retries             (state.retries),
    .result              (sel_result)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state         = state;
    next_state.gp      = gp_after_host;
    next_state.valid   = eval_req;
    next_state.execute = 1'b0;
    next_state.skip    = 1'b0;
    if (cfg_write)
    begin
      next_state.cfg = cfg_wdata;
    end
    if (msg_done)
    begin
      next_state.no_reply     = msg_no_reply;
      next_state.format_fault = fmt_now;
      next_state.faulty       = bad_now;
      next_state.retries      = msg_retries;
      next_state.masked       = ~msg_no_reply & (
          (|mask_hits)
        | (~msg_control_word[CW_RSVD_MASK]
           & (|msg_status_word[SW_RSVD_HI:SW_RSVD_LO]))
        | (state.cfg[CFG_BCAST_MASK_EN] & ~msg_control_word[CW_MASK_BCAST]
           & msg_status_word[SW_BCAST_RCVD]));
      if (bad_now)
      begin
        next_state.clean_block = 1'b0;
      end
      else
      begin
        case (msg_kind)
          MSG_RT_TO_BC, MSG_RT_TO_RT, MSG_TX_MODE_DATA:
            next_state.clean_block = 1'b1;
          default:
            next_state.clean_block = 1'b0;
        endcase
      end
    end
    if (eval_req)
    begin
      next_state.result  = sel_result;
      next_state.execute = sel_result;
      next_state.skip    = ~sel_result;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state     <= '0;
      state.cfg <= BC_CONFIG_RESET;
      state.gp  <= GP_WIDTH'(GP_FLAGS_RESET);
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign eval_valid                   = state.valid;
  assign eval_true                    = state.result;
  assign execute                      = state.execute;
  assign skip                         = state.skip;
  assign bus_controller_configuration = state.cfg;
  assign no_reply_timeout_sel         = state.cfg[CFG_TIMEOUT_HI:CFG_TIMEOUT_LO];
  assign gp_flags                     = state.gp;
  assign no_reply_flag                = state.no_reply;
  assign format_fault_flag            = state.format_fault;
  assign clean_block_flag             = state.clean_block;
  assign masked_status_flag           = state.masked;
  assign faulty_message_flag          = state.faulty;

endmodule : bc_condition_code_eval
`default_nettype wire

// ---- tb/bc_cc_chk.sv ----
/*
  Checker for the condition-code evaluator, bound to its top module.
  Assumes one clock domain and the asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module bc_cc_chk
  import bc_cc_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        rstn,
  // Inputs watched
  input wire logic        cfg_write,
  input wire logic [15:0] cfg_wdata,
  input wire logic        msg_done,
  input wire logic        msg_no_reply,
  input wire logic        msg_bad_word,
  input wire logic        msg_loopback_fault,
  input wire logic        eval_req,
  input wire logic [4:0]  eval_cond,
  // Outputs judged
  input wire logic        eval_valid,
  input wire logic        eval_true,
  input wire logic        execute,
  input wire logic        skip,
  input wire logic [15:0] bus_controller_configuration,
  input wire logic [1:0]  no_reply_timeout_sel,
  input wire logic        no_reply_flag,
  input wire logic        clean_block_flag,
  input wire logic        faulty_message_flag
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  req_answer_a: assert property (eval_req |=> eval_valid && (execute != skip))
    else $error("evaluation not answered by exactly one outcome");
  valid_only_a: assert property (!eval_req |=> !eval_valid && !execute && !skip)
    else $error("outcome without request");
  exec_true_a: assert property (eval_valid |-> execute == eval_true)
    else $error("execute differs from result");
  result_hold_a: assert property (!eval_req |=> $stable(eval_true))
    else $error("result moved without a request");
  always_code_a: assert property (eval_req && eval_cond == 5'h0F |=> execute)
    else $error("always code skipped");
  never_code_a: assert property (eval_req && eval_cond == 5'h1F |=> skip)
    else $error("never code executed");
  no_reply_a: assert property (msg_done |=> no_reply_flag == $past(msg_no_reply))
    else $error("no reply flag wrong");
  bad_msg_a: assert property (msg_done && (msg_no_reply || msg_bad_word
    || msg_loopback_fault) |=> faulty_message_flag) else $error("faulty flag missed");
  clean_clr_a: assert property (msg_done && msg_no_reply |=> !clean_block_flag)
    else $error("clean block kept on failed message");
  flag_hold_a: assert property (!msg_done |=> $stable(faulty_message_flag)
    && $stable(clean_block_flag)) else $error("message flags moved between messages");
  cfg_load_a: assert property (cfg_write |=> bus_controller_configuration ==
    $past(cfg_wdata) && no_reply_timeout_sel == $past(cfg_wdata[15:14]))
    else $error("configuration not loaded");
endmodule : bc_cc_chk

bind bc_condition_code_eval bc_cc_chk chk (.clock(clock), .rstn(rstn),
  .cfg_write(cfg_write), .cfg_wdata(cfg_wdata), .msg_done(msg_done),
  .msg_no_reply(msg_no_reply), .msg_bad_word(msg_bad_word),
  .msg_loopback_fault(msg_loopback_fault), .eval_req(eval_req), .eval_cond(eval_cond),
  .eval_valid(eval_valid), .eval_true(eval_true), .execute(execute), .skip(skip),
  .bus_controller_configuration(bus_controller_configuration),
  .no_reply_timeout_sel(no_reply_timeout_sel), .no_reply_flag(no_reply_flag),
  .clean_block_flag(clean_block_flag), .faulty_message_flag(faulty_message_flag));
`default_nettype wire

// ---- tb/bc_msg_model.sv ----
/*
  Message engine and remote terminal stand-in: reports one finished message.
  Assumes send is called at a falling edge from one process only.
*/
`timescale 1ns/1ps
`default_nettype none
module bc_msg_model
  import bc_cc_pkg::*;
(
  // Clock
  input  wire logic   clock,
  // Message report
  output var msg_kind_t msg_kind,
  output logic        msg_done,
  output logic [2:0]  msg_err,
  output logic [4:0]  msg_rt_addr,
  output logic [15:0] msg_status_word,
  output logic [15:0] msg_control_word,
  output logic [1:0]  msg_retries
);
  initial
  begin
    msg_kind = MSG_RT_TO_BC;
    {msg_done, msg_err, msg_rt_addr, msg_retries} = '0;
    {msg_status_word, msg_control_word} = '0;
  end

  // Error bits: no reply, bad word, loopback; timeout judged here, not in the block
  task automatic send(input msg_kind_t k, input logic [2:0] e, input logic [15:0] sw,
                      input logic [15:0] cw, input logic [1:0] rt);
    @(negedge clock);
    msg_kind = k;
    {msg_err, msg_status_word, msg_control_word} = {e, sw, cw};
    {msg_rt_addr, msg_retries, msg_done} = {5'h05, rt, 1'b1};
    @(negedge clock);
    msg_done = 1'b0;
    // Fields are stale once done drops, so show something else
    msg_kind = (k == MSG_RT_TO_BC) ? MSG_BC_TO_RT : MSG_RT_TO_BC;
    {msg_err, msg_status_word, msg_control_word} = ~{e, sw, cw};
    {msg_rt_addr, msg_retries} = ~{5'h05, rt};
  endtask : send
endmodule : bc_msg_model
`default_nettype wire

// ---- tb/testbench.sv ----
/*
  Self-checking bench for the condition-code evaluator.
  Assumes the message model drives every message input of the block.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bc_cc_pkg::*;
  logic clock = 1'b0, rstn = 1'b0, cfg_write = 1'b0, gp_host_write = 1'b0;
  logic flg_exec = 1'b0, eval_req = 1'b0, eval_valid, eval_true, execute, skip;
  logic [15:0] cfg_wdata = 16'h0000, cfg, msg_status_word, msg_control_word;
  gp_op_t gp_host_op = GP_HOLD, flg_op = GP_HOLD;
  msg_kind_t msg_kind;
  logic [7:0] gp_host_bits = 8'h00, flg_bits = 8'h00, gp_flags;
  logic [4:0] eval_cond = 5'h00, msg_rt_addr;
  wire logic [4:0] fl;
  logic [2:0] msg_err;
  logic [1:0] msg_retries, tsel;
  logic msg_done;
  int error_cnt = 0, n_checks = 0;

  always #2 clock = ~clock;

  bc_condition_code_eval DUT (.clock(clock), .rstn(rstn), .cfg_write(cfg_write),
    .cfg_wdata(cfg_wdata), .gp_host_write(gp_host_write), .gp_host_op(gp_host_op),
    .gp_host_bits(gp_host_bits), .flg_exec(flg_exec), .flg_op(flg_op), .flg_bits(flg_bits),
    .msg_done(msg_done), .msg_kind(msg_kind), .msg_no_reply(msg_err[2]),
    .msg_bad_word(msg_err[1]), .msg_loopback_fault(msg_err[0]), .msg_rt_addr(msg_rt_addr),
    .msg_status_word(msg_status_word), .msg_control_word(msg_control_word),
    .msg_retries(msg_retries), .eval_req(eval_req), .eval_cond(eval_cond),
    .eval_valid(eval_valid), .eval_true(eval_true), .execute(execute), .skip(skip),
    .bus_controller_configuration(cfg), .no_reply_timeout_sel(tsel), .gp_flags(gp_flags),
    .no_reply_flag(fl[4]), .format_fault_flag(fl[3]), .clean_block_flag(fl[2]),
    .masked_status_flag(fl[1]), .faulty_message_flag(fl[0]));
  bc_msg_model pm (.clock(clock), .msg_kind(msg_kind), .msg_done(msg_done),
    .msg_err(msg_err), .msg_rt_addr(msg_rt_addr), .msg_status_word(msg_status_word),
    .msg_control_word(msg_control_word), .msg_retries(msg_retries));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // Request stays high between back-to-back calls; callers drop it afterwards
  task automatic ev(input logic [4:0] c, input logic x);
    {eval_cond, eval_req} = {c, 1'b1};
    @(negedge clock);
    check({eval_valid, execute, skip, eval_true}, {1'b1, x, !x, x});
  endtask : ev

  task automatic wcfg(input logic [15:0] d);
    {cfg_wdata, cfg_write} = {d, 1'b1};
    @(negedge clock);
    cfg_write = 1'b0;
    check(cfg, d);
    check(tsel, d[15:14]);
  endtask : wcfg

  task automatic gpo(input gp_op_t ho, input logic [7:0] hb, input gp_op_t fo,
                     input logic [7:0] fb, input logic [7:0] exp);
    gp_host_write = 1'b1;
    flg_exec = 1'b1;
    gp_host_op = ho;
    gp_host_bits = hb;
    flg_op = fo;
    flg_bits = fb;
    @(negedge clock);
    check(gp_flags, exp);
  endtask : gpo

  task automatic t_gp;
    logic [7:0] gexp = 8'h60;
    gpo(GP_SET, 8'hF0, GP_TOGGLE, 8'h3C, 8'hFC);
    gpo(GP_CLEAR, 8'h0C, GP_SET, 8'h01, 8'hF1);
    gpo(GP_TOGGLE, 8'h81, GP_CLEAR, 8'h10, 8'h60);
    gpo(GP_HOLD, 8'hFF, GP_HOLD, 8'hFF, 8'h60);
    for (int n = 0; n < 8; n++)
    begin
      ev({2'b00, 3'(n)}, gexp[n]);
      ev({2'b10, 3'(n)}, !gexp[n]);
    end
    {gp_host_write, flg_exec, eval_req} = 3'b000;
    $display("general flag test done");
  endtask : t_gp

  // Expected flags f: no reply, format, clean block, masked, faulty
  task automatic msg(input msg_kind_t k, input logic [2:0] e, input logic [15:0] sw,
                     input logic [15:0] cw, input logic [1:0] rt, input logic [4:0] f);
    pm.send(k, e, sw, cw, rt);
    check(fl, f);
    for (int i = 0; i < 5; i++)
    begin
      ev({1'b0, 4'(CC_NO_REPLY + i)}, f[4-i]);
      ev({1'b1, 4'(CC_NO_REPLY + i)}, !f[4-i]);
    end
    ev(5'h0D, rt != RETRY_NONE);
    ev(5'h1D, rt == RETRY_NONE);
    // The inverted two-retry code is never issued
    ev(5'h0E, rt == RETRY_TWO);
    ev(5'h0F, 1'b1);
    ev(5'h1F, 1'b0);
    eval_req = 1'b0;
  endtask : msg

  task automatic t_msgs;
    wcfg(16'hC001);
    msg(MSG_RT_TO_BC, 3'b000, 16'h2800, 16'h7E20, 2'h0, 5'b00100);
    msg(MSG_BC_TO_RT, 3'b000, 16'h2C00, 16'h0000, 2'h1, 5'b00010);
    msg(MSG_RT_TO_RT, 3'b000, 16'h3000, 16'h7E20, 2'h2, 5'b01001);
    msg(MSG_RT_TO_BC, 3'b100, 16'h2C00, 16'h0000, 2'h0, 5'b10001);
    msg(MSG_RT_TO_BC, 3'b010, 16'h2800, 16'h7E20, 2'h1, 5'b01001);
    msg(MSG_TX_MODE_DATA, 3'b001, 16'h2800, 16'h7E20, 2'h0, 5'b00001);
    msg(MSG_RT_TO_RT, 3'b000, 16'h2820, 16'h7C20, 2'h0, 5'b00110);
    msg(MSG_RX_MODE_DATA, 3'b000, 16'h2810, 16'h7E00, 2'h0, 5'b00010);
    wcfg(16'h4000);
    msg(MSG_TX_MODE_DATA, 3'b000, 16'h2800, 16'h7E20, 2'h0, 5'b00100);
    msg(MSG_MODE_NO_DATA, 3'b000, 16'h2810, 16'h7E00, 2'h0, 5'b00000);
    $display("message flag test done");
  endtask : t_msgs

  // Reset in mid-run must clear flags, configuration and outcome at once
  task automatic t_reset;
    rstn = 1'b0;
    #1;
    check({gp_flags, fl}, 13'h0);
    check(cfg, BC_CONFIG_RESET);
    check({eval_valid, execute, skip, eval_true}, 4'h0);
    @(negedge clock);
    rstn = 1'b1;
    ev(5'h0F, 1'b1);
    eval_req = 1'b0;
    $display("mid-run reset test done");
  endtask : t_reset

  initial
  begin
    repeat (10) @(negedge clock);
    rstn = 1'b1;
    check(cfg, BC_CONFIG_RESET);
    check({gp_flags, fl}, 13'h0);
    $display("reset test done");
    t_gp;
    t_msgs;
    t_reset;
    wrap_up;
  end

  initial
  begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    wrap_up;
  end
endmodule : testbench
`default_nettype wire
